// [core/qlc_pkg.sv]
// Package for the quad-linear sensor line timing generator.
// Assumes a 250 MHz system clock and external level-shifting clock drivers.
package qlc_pkg;

  localparam int unsigned CLK_MHZ            = 250;
  localparam int unsigned PIX_MAX_MHZ        = 30;
  // Fastest pixel period in system clocks, rounded up so the pixel rate stays at or under the limit
  localparam int unsigned PIX_MIN_CYC        = (CLK_MHZ + PIX_MAX_MHZ - 1) / PIX_MAX_MHZ;
  localparam int unsigned VIDEO_OUTPUTS      = 7;
  localparam int unsigned LUMA_OUTPUTS       = 4;
  localparam int unsigned LUMA_ACTIVE        = 8160;
  localparam int unsigned CHROMA_ACTIVE      = 4080;
  localparam int unsigned LEAD_BLANK         = 4;
  localparam int unsigned LEAD_DARK          = 24;
  localparam int unsigned TRAIL_GROUP        = 24;
  localparam int unsigned TRAIL_DARK         = 16;
  localparam int unsigned LINE_PIXELS        = LEAD_BLANK + LEAD_DARK + CHROMA_ACTIVE + TRAIL_GROUP;
  localparam int unsigned GATE_STEP_CYC_DEF  = 8;
  localparam int unsigned RESET_PULSE_CYC    = 1;
  localparam logic [15:0] PIX_CNT_RST        = 16'h0000;
  localparam logic [7:0]  STEP_CNT_RST       = 8'h00;

  typedef enum logic [2:0] {
    QLC_IDLE     = 3'b000,
    QLC_PARK     = 3'b001,
    QLC_GATES_ON = 3'b010,
    QLC_G1_OFF   = 3'b011,
    QLC_G2_OFF   = 3'b100,
    QLC_SHIFT    = 3'b101
  } qlc_state_t;

  typedef enum logic [1:0] {
    QLC_SEG_BLANK  = 2'b00,
    QLC_SEG_DARK   = 2'b01,
    QLC_SEG_ACTIVE = 2'b10,
    QLC_SEG_TRAIL  = 2'b11
  } qlc_seg_t;

  typedef struct packed {
    logic first_transfer_gate;
    logic second_transfer_gate;
    logic chroma_phase_one_clock;
    logic chroma_phase_two_clock;
    logic reset_clock;
  } qlc_chroma_pins_t;

  typedef struct packed {
    logic luma_first_gate_bias;
    logic luma_second_gate;
    logic luma_phase_one_clock;
    logic luma_phase_two_clock;
    logic reset_clock;
  } qlc_luma_pins_t;

  // Pin levels after reset: gates shut, phases parked, luma bias on
  localparam qlc_chroma_pins_t CHROMA_PINS_RST = 5'h04;
  localparam qlc_luma_pins_t   LUMA_PINS_RST   = 5'h14;

endpackage

// [core/qlc_timing_gen.sv]
// Line timing generator driving transfer gates, phase clocks and reset clocks.
// Assumes pins drive external clock drivers; no other sensor logic is modelled.
`timescale 1ns/1ps
`default_nettype none
module qlc_timing_gen
  import qlc_pkg::*;
#(
  parameter int unsigned PIX_CYC       = PIX_MIN_CYC,
  parameter int unsigned GATE_STEP_CYC = GATE_STEP_CYC_DEF,
  parameter int unsigned LINE_PIX      = LINE_PIXELS
)(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       line_start,
  output qlc_chroma_pins_t chroma_pins,
  output qlc_luma_pins_t  luma_pins,
  output logic            busy,
  output logic            pixel_valid,
  output qlc_seg_t        pixel_seg,
  output logic [15:0]     pixel_index
);

  // ---------------------------------------------------------------
  // Start synchroniser
  // ---------------------------------------------------------------
  logic sync1_q;
  logic sync2_q;
  logic sync1_d;
  logic sync2_d;

  always_comb
  begin
    sync1_d = line_start;
    sync2_d = sync1_q;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end
    else
    begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
    end
  end

  function automatic qlc_seg_t seg_of(input logic [15:0] idx);
    if (idx < 16'(LEAD_BLANK))
      return QLC_SEG_BLANK;
    else if (idx < 16'(LEAD_BLANK + LEAD_DARK))
      return QLC_SEG_DARK;
    else if (idx < 16'(LEAD_BLANK + LEAD_DARK + CHROMA_ACTIVE))
      return QLC_SEG_ACTIVE;
    else
      return QLC_SEG_TRAIL;
  endfunction

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  qlc_state_t       state_q, state_d;
  logic [7:0]       step_q, step_d;
  logic [7:0]       pcyc_q, pcyc_d;
  logic [15:0]      pix_q, pix_d;
  qlc_chroma_pins_t cp_q, cp_d;
  qlc_luma_pins_t   lp_q, lp_d;
  logic             busy_q, busy_d;
  logic             pv_q, pv_d;
  qlc_seg_t         seg_q, seg_d;
  logic [15:0]      idx_q, idx_d;
  logic             step_done;

  localparam logic [7:0] STEP_LAST = 8'(GATE_STEP_CYC - 1);
  localparam logic [7:0] PIX_LAST  = 8'(PIX_CYC - 1);
  localparam logic [7:0] PIX_HALF  = 8'(PIX_CYC / 2);
  localparam logic [7:0] RST_END   = 8'(RESET_PULSE_CYC);

  assign step_done = (step_q == STEP_LAST);

  always_comb
  begin
    state_d = state_q;
    step_d  = step_done ? STEP_CNT_RST : step_q + 8'h01;
    pcyc_d  = pcyc_q;
    pix_d   = pix_q;
    cp_d    = cp_q;
    lp_d    = lp_q;
    busy_d  = busy_q;
    pv_d    = 1'b0;
    seg_d   = seg_q;
    idx_d   = idx_q;
    lp_d.luma_first_gate_bias = 1'b1;
    unique case (state_q)
      QLC_IDLE:
      begin
        step_d = STEP_CNT_RST;
        busy_d = 1'b0;
        cp_d.first_transfer_gate  = 1'b0;
        cp_d.second_transfer_gate = 1'b0;
        lp_d.luma_second_gate     = 1'b0;
        if (sync2_q)
        begin
          state_d = QLC_PARK;
          busy_d  = 1'b1;
        end
      end
      QLC_PARK:
      begin
        cp_d.chroma_phase_one_clock = 1'b1;
        cp_d.chroma_phase_two_clock = 1'b0;
        lp_d.luma_phase_one_clock   = 1'b1;
        lp_d.luma_phase_two_clock   = 1'b0;
        cp_d.reset_clock = 1'b0;
        lp_d.reset_clock = 1'b0;
        if (step_done)
        begin
          state_d = QLC_GATES_ON;
          cp_d.first_transfer_gate  = 1'b1;
          cp_d.second_transfer_gate = 1'b1;
          lp_d.luma_second_gate     = 1'b1;
        end
      end
      QLC_GATES_ON:
        if (step_done)
        begin
          state_d = QLC_G1_OFF;
          cp_d.first_transfer_gate = 1'b0;
          lp_d.luma_second_gate    = 1'b0;
        end
      QLC_G1_OFF:
        if (step_done)
        begin
          state_d = QLC_G2_OFF;
          cp_d.second_transfer_gate = 1'b0;
        end
      QLC_G2_OFF:
        if (step_done)
        begin
          state_d = QLC_SHIFT;
          pcyc_d  = 8'h00;
          pix_d   = PIX_CNT_RST;
          // First pixel opens like every other: reset pulse, phase two high
          cp_d.reset_clock = 1'b1;
          lp_d.reset_clock = 1'b1;
          cp_d.chroma_phase_one_clock = 1'b0;
          cp_d.chroma_phase_two_clock = 1'b1;
          lp_d.luma_phase_one_clock   = 1'b0;
          lp_d.luma_phase_two_clock   = 1'b1;
        end
      QLC_SHIFT:
      begin
        step_d = STEP_CNT_RST;
        pcyc_d = (pcyc_q == PIX_LAST) ? 8'h00 : pcyc_q + 8'h01;
        // Reset pulse leads each pixel
        cp_d.reset_clock = (pcyc_d < RST_END);
        lp_d.reset_clock = (pcyc_d < RST_END);
        // Both registers share one complementary pair timing
        cp_d.chroma_phase_one_clock = (pcyc_d >= PIX_HALF);
        cp_d.chroma_phase_two_clock = (pcyc_d <  PIX_HALF);
        lp_d.luma_phase_one_clock   = (pcyc_d >= PIX_HALF);
        lp_d.luma_phase_two_clock   = (pcyc_d <  PIX_HALF);
        if (pcyc_q == PIX_HALF - 8'h01)
        begin
          // Phase two falls next: pixel lands on all seven outputs
          pv_d  = 1'b1;
          seg_d = seg_of(pix_q);
          idx_d = pix_q;
        end
        if (pcyc_q == PIX_LAST)
        begin
          pix_d = pix_q + 16'h0001;
          if (pix_q == 16'(LINE_PIX - 1))
          begin
            state_d = QLC_IDLE;
            cp_d.chroma_phase_one_clock = 1'b1;
            cp_d.chroma_phase_two_clock = 1'b0;
            lp_d.luma_phase_one_clock   = 1'b1;
            lp_d.luma_phase_two_clock   = 1'b0;
            cp_d.reset_clock = 1'b0;
            lp_d.reset_clock = 1'b0;
          end
        end
      end
      default:
        state_d = QLC_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= QLC_IDLE;
      step_q  <= STEP_CNT_RST;
      pcyc_q  <= 8'h00;
      pix_q   <= PIX_CNT_RST;
      cp_q    <= CHROMA_PINS_RST;
      lp_q    <= LUMA_PINS_RST;
      busy_q  <= 1'b0;
      pv_q    <= 1'b0;
      seg_q   <= QLC_SEG_BLANK;
      idx_q   <= PIX_CNT_RST;
    end
    else
    begin
      state_q <= state_d;
      step_q  <= step_d;
      pcyc_q  <= pcyc_d;
      pix_q   <= pix_d;
      cp_q    <= cp_d;
      lp_q    <= lp_d;
      busy_q  <= busy_d;
      pv_q    <= pv_d;
      seg_q   <= seg_d;
      idx_q   <= idx_d;
    end
  end

  assign chroma_pins = cp_q;
  assign luma_pins   = lp_q;
  assign busy        = busy_q;
  assign pixel_valid = pv_q;
  assign pixel_seg   = seg_q;
  assign pixel_index = idx_q;

endmodule
`default_nettype wire

// [dv/qlc_timing_gen_chk.sv]
// Port assertions for the line timing generator.
// Assumes default pixel and gate step lengths of 9 and 8 cycles.
`timescale 1ns/1ps
`default_nettype none
module qlc_timing_gen_chk
  import qlc_pkg::*;
#(
  parameter int unsigned LINE_PIX = LINE_PIXELS
)(
  input wire logic             clk,
  input wire logic             rst,
  input wire logic             line_start,
  input wire qlc_chroma_pins_t chroma_pins,
  input wire qlc_luma_pins_t   luma_pins,
  input wire logic             busy,
  input wire logic             pixel_valid,
  input wire qlc_seg_t         pixel_seg,
  input wire logic [15:0]      pixel_index
);
  // Gates 4:3, phases 2:1, reset clock 0
  wire logic [4:0] c = chroma_pins;
  wire logic [4:0] l = luma_pins;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_on; c[4:3] == 2'h3 && l[3]; endsequence
  sequence s_g2; c[4:3] == 2'h1 && !l[3]; endsequence
  a_gates_idle: assert property (!busy |-> c[4:3] == 2'h0 && !l[3]) else $error("gate open in idle");
  a_phase_park: assert property (!busy |-> c[2:1] == 2'h2 && l[2:1] == 2'h2) else $error("not parked");
  a_gate_order: assert property ($rose(c[3]) |-> s_on [*8] ##1 s_g2 [*8] ##1 !c[3])
    else $error("gate order");
  a_bias_held: assert property (l[4]) else $error("luma bias off");
  a_read_resume: assert property ($fell(c[3]) |-> ##[1:30] pixel_valid) else $error("no readout");
  a_phase_compl: assert property (pixel_valid |-> c[2] != c[1] && c[2:1] == l[2:1]) else $error("phases");
  a_h2_fall: assert property (pixel_valid |-> ##[0:1] $fell(c[1])) else $error("no phase two fall");
  a_reset_pulse: assert property ($rose(c[1]) |-> c[0] && l[0]) else $error("no reset pulse");
  a_pix_rate: assert property (pixel_valid |=> !pixel_valid [*8]) else $error("pixel rate");
  a_index_range: assert property (pixel_valid |-> pixel_index < 16'(LINE_PIX)) else $error("index range");
endmodule
bind qlc_timing_gen qlc_timing_gen_chk #(.LINE_PIX(LINE_PIX)) u_chk (.clk(clk), .rst(rst), .line_start(line_start),
  .chroma_pins(chroma_pins), .luma_pins(luma_pins), .busy(busy), .pixel_valid(pixel_valid),
  .pixel_seg(pixel_seg), .pixel_index(pixel_index));
`default_nettype wire

// [dv/qlc_sensor_model.sv]
// Sensor model: counts pixels moved to the outputs, notes charge loaded, flag held until reset.
// Assumes pins are sampled on the system clock.
`timescale 1ns/1ps
`default_nettype none
module qlc_sensor_model
  import qlc_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire qlc_chroma_pins_t chroma_pins,
  input  wire qlc_luma_pins_t   luma_pins,
  output logic [15:0]           pix_cnt,
  output logic                  line_loaded
);
  logic [4:0] c_q;
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      c_q <= 5'h04;
      pix_cnt <= 16'h0000;
      line_loaded <= 1'b0;
    end
    else
    begin
      c_q <= chroma_pins;
      if (chroma_pins.first_transfer_gate)
        pix_cnt <= 16'h0000;
      if (c_q[4] && !chroma_pins.first_transfer_gate && chroma_pins.second_transfer_gate)
        line_loaded <= 1'b1;
      if (c_q[1] && !chroma_pins.chroma_phase_two_clock && !luma_pins.luma_phase_two_clock)
        pix_cnt <= pix_cnt + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// [dv/test_qlc_timing_gen.sv]
// Self-checking bench for the line timing generator.
// Assumes default parameters; one full line runs about 37k cycles.
`timescale 1ns/1ps
`default_nettype none
module test_qlc_timing_gen
  import qlc_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic line_start = 1'b0;
  qlc_chroma_pins_t chroma_pins;
  qlc_luma_pins_t luma_pins;
  logic busy, pixel_valid, line_loaded;
  qlc_seg_t pixel_seg;
  logic [15:0] pixel_index, pix_cnt;
  int num_errors = 0;
  int compares = 0;

  qlc_timing_gen DUT (.clk(clk), .rst(rst), .line_start(line_start), .chroma_pins(chroma_pins),
    .luma_pins(luma_pins), .busy(busy), .pixel_valid(pixel_valid), .pixel_seg(pixel_seg), .pixel_index(pixel_index));
  qlc_sensor_model u_model (.clk(clk), .rst(rst), .chroma_pins(chroma_pins), .luma_pins(luma_pins),
    .pix_cnt(pix_cnt), .line_loaded(line_loaded));

  initial
  begin
    forever #2 clk = ~clk;
  end

  // ----
  // Tasks
  // ----
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  function automatic logic [15:0] exp_seg(int k);
    if (k < LEAD_BLANK) return 16'h0000;
    if (k < LEAD_BLANK + LEAD_DARK) return 16'h0001;
    if (k < LEAD_BLANK + LEAD_DARK + CHROMA_ACTIVE) return 16'h0002;
    return 16'h0003;
  endfunction

  task automatic park_levels();
    @(negedge clk);
    check("chroma pins", 16'(chroma_pins), 16'h0004);
    check("luma pins", 16'(luma_pins), 16'h0014);
    check("busy", 16'(busy), 16'h0000);
  endtask

  task automatic start_line();
    int t;
    @(posedge clk);
    line_start <= 1'b1;
    t = 0;
    @(negedge clk);
    while (busy !== 1'b1 && t < 8)
    begin
      @(negedge clk);
      t++;
    end
    check("busy", 16'(busy), 16'h0001);
    @(posedge clk);
    line_start <= 1'b0;
  endtask

  task automatic mid_reset();
    start_line();
    repeat (10) @(posedge clk);
    @(negedge clk);
    check("gates on", 16'(chroma_pins[4:3]), 16'h0003);
    @(posedge clk);
    rst <= 1'b1;
    park_levels();
    @(posedge clk);
    rst <= 1'b0;
  endtask

  task automatic line_scan();
    int k, t;
    start_line();
    for (k = 0; k < LINE_PIXELS; k++)
    begin
      t = 0;
      @(negedge clk);
      while (pixel_valid !== 1'b1 && t < 60)
      begin
        @(negedge clk);
        t++;
      end
      check("index", pixel_index, k[15:0]);
      check("segment", 16'(pixel_seg), exp_seg(k));
      if (k == 100)
      begin
        @(posedge clk);
        line_start <= 1'b1;
        @(posedge clk);
        line_start <= 1'b0;
      end
    end
    t = 0;
    while (busy !== 1'b0 && t < 40)
    begin
      @(negedge clk);
      t++;
    end
    check("pixels out", pix_cnt, 16'(LINE_PIXELS));
    check("loaded", 16'(line_loaded), 16'h0001);
    repeat (12) @(negedge clk);
    check("no restart", 16'(busy), 16'h0000);
  endtask

  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    park_levels();
    mid_reset();
    park_levels();
    line_scan();
    complete_run();
  end

  initial
  begin
    #200us;
    num_errors++;
    complete_run();
  end
endmodule
`default_nettype wire
